// ### src/wwd_interval.sv
// Purpose: interval timer counting timebase ticks derived from clk
// Assumes: len is at least one tick
// Notes:   interval lasts len*tick_cycles clocks after load, then expired stays high

`timescale 1ns/1ns

module wwd_interval #(
    parameter int unsigned TICK_CYCLES = wwd_pkg::TICK_CYCLES
) (
    input  wire logic  clk,
    input  wire logic  resetn,
    wwd_timer_if.tmr   tif
);

    localparam logic [15:0] PRE_RELOAD = 16'(TICK_CYCLES - 1);

    logic [15:0]                pre;
    logic [wwd_pkg::TICK_W-1:0] cnt;
    wire                        tick = (pre == 16'h0000);

    // ------------------------------------------------------------
    // prescaler restarts on load so every interval is exact
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre <= 16'h0000;
        end else if (tif.load || tick) begin
            pre <= PRE_RELOAD;
        end else begin
            pre <= pre - 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= '0;
        end else if (tif.load) begin
            cnt <= tif.len;
        end else if (tick && cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    assign tif.expired = (cnt == '0);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    load_takes_len_a: assert property (@(posedge clk) disable iff (!resetn)
        tif.load |=> (cnt == $past(tif.len)) && (pre == PRE_RELOAD))
        else $error("interval did not take its length on load");

endmodule // wwd_interval

// ### src/wwd_pkg.sv
// Purpose: shared constants for the windowed watchdog supervisor
// Assumes: 10 MHz system clock, timebase tick of 100 us
// Notes:   window times are counted in timebase ticks

package wwd_pkg;

    // ------------------------------------------------------------
    // clock and timebase
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TICK_TIME_US  = 100;
    localparam int unsigned TICK_CYCLES   = (TICK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // watchdog times, in microseconds as specified
    // ------------------------------------------------------------
    localparam int unsigned CLOSED_WINDOW_TIME_US = 80000;
    localparam int unsigned OPEN_WINDOW_TIME_US   = 40000;
    localparam int unsigned RESET_PULSE_WIDTH_US  = 2500;
    localparam int unsigned POWER_ON_DELAY_US     = 100000;

    // ------------------------------------------------------------
    // the same times as tick counts
    // ------------------------------------------------------------
    localparam int unsigned TICK_W      = 16;
    localparam int unsigned CW_TICKS    = CLOSED_WINDOW_TIME_US / TICK_TIME_US;
    localparam int unsigned OW_TICKS    = OPEN_WINDOW_TIME_US / TICK_TIME_US;
    localparam int unsigned WDR_TICKS   = RESET_PULSE_WIDTH_US / TICK_TIME_US;
    localparam int unsigned POR_TICKS   = POWER_ON_DELAY_US / TICK_TIME_US;

    // ------------------------------------------------------------
    // service counting and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] SERVICES_NEEDED = 2'h3;
    localparam logic [1:0] SVC_COUNT_RST   = 2'h0;
    localparam logic       CLEAR_IDLE      = 1'h1;
    localparam logic       SUPPLY_RST      = 1'h0;

    typedef enum logic [2:0] {
        WWD_SUPPLY_LOW,
        WWD_POR,
        WWD_CLOSED,
        WWD_OPEN,
        WWD_RESET
    } wwd_state_e;

endpackage

// ### src/wwd_supervisor.sv
// Purpose: windowed watchdog supervisor with supply-low override and system enable
// Assumes: clear and supply inputs are asynchronous pins; reset pin is open drain
// Notes:   a service is a falling edge on watchdog_clear_n after two-flop synchronising

`timescale 1ns/1ns

module wwd_supervisor #(
    parameter int unsigned TICK_CYCLES = wwd_pkg::TICK_CYCLES,
    parameter int unsigned CW_TICKS    = wwd_pkg::CW_TICKS,
    parameter int unsigned OW_TICKS    = wwd_pkg::OW_TICKS,
    parameter int unsigned WDR_TICKS   = wwd_pkg::WDR_TICKS,
    parameter int unsigned POR_TICKS   = wwd_pkg::POR_TICKS
) (
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  watchdog_clear_n,
    input  wire logic  supply_ok,
    output wire logic  system_reset_n,
    output wire logic  system_reset_oe_n,
    output wire logic  system_enable_n
);

    localparam logic [wwd_pkg::TICK_W-1:0] CW_LEN  = wwd_pkg::TICK_W'(CW_TICKS);
    localparam logic [wwd_pkg::TICK_W-1:0] OW_LEN  = wwd_pkg::TICK_W'(OW_TICKS);
    localparam logic [wwd_pkg::TICK_W-1:0] WDR_LEN = wwd_pkg::TICK_W'(WDR_TICKS);
    localparam logic [wwd_pkg::TICK_W-1:0] POR_LEN = wwd_pkg::TICK_W'(POR_TICKS);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic clr_meta;
    logic clr_sync;
    logic clr_prev;
    logic sup_meta;
    logic sup_sync;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clr_meta <= wwd_pkg::CLEAR_IDLE;
            clr_sync <= wwd_pkg::CLEAR_IDLE;
            clr_prev <= wwd_pkg::CLEAR_IDLE;
        end else begin
            clr_meta <= watchdog_clear_n;
            clr_sync <= clr_meta;
            clr_prev <= clr_sync;
        end
    end

    // supply starts low so every power-up passes the power-on delay
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sup_meta <= wwd_pkg::SUPPLY_RST;
            sup_sync <= wwd_pkg::SUPPLY_RST;
        end else begin
            sup_meta <= supply_ok;
            sup_sync <= sup_meta;
        end
    end

    wire clr_fall = clr_prev & ~clr_sync;

    // ------------------------------------------------------------
    // interval timer
    // ------------------------------------------------------------
    wwd_timer_if tif ();

    wwd_interval #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_interval (
        .clk    (clk),
        .resetn (resetn),
        .tif    (tif)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    wwd_pkg::wwd_state_e state;
    wwd_pkg::wwd_state_e next_state;
    logic [1:0]          svc_count;
    logic [1:0]          next_svc_count;

    wire in_closed  = (state == wwd_pkg::WWD_CLOSED);
    wire in_open    = (state == wwd_pkg::WWD_OPEN);
    wire good_svc   = in_open & clr_fall;
    wire early_svc  = in_closed & clr_fall;
    wire reset_act  = (state == wwd_pkg::WWD_SUPPLY_LOW) | (state == wwd_pkg::WWD_POR) |
                      (state == wwd_pkg::WWD_RESET);
    wire svc_done   = (svc_count == wwd_pkg::SERVICES_NEEDED);

    always_comb begin
        next_state = state;
        if (!sup_sync) begin
            next_state = wwd_pkg::WWD_SUPPLY_LOW;
        end else begin
            case (state)
                wwd_pkg::WWD_SUPPLY_LOW: begin
                    next_state = wwd_pkg::WWD_POR;
                end
                wwd_pkg::WWD_POR: begin
                    // clear edges are not looked at here
                    if (tif.expired) begin
                        next_state = wwd_pkg::WWD_CLOSED;
                    end
                end
                wwd_pkg::WWD_CLOSED: begin
                    if (clr_fall) begin
                        next_state = wwd_pkg::WWD_RESET;
                    end else if (tif.expired) begin
                        next_state = wwd_pkg::WWD_OPEN;
                    end
                end
                wwd_pkg::WWD_OPEN: begin
                    if (clr_fall) begin
                        next_state = wwd_pkg::WWD_CLOSED;
                    end else if (tif.expired) begin
                        next_state = wwd_pkg::WWD_RESET;
                    end
                end
                wwd_pkg::WWD_RESET: begin
                    // back to closed keeps the failure loop at closed+open+pulse
                    if (tif.expired) begin
                        next_state = wwd_pkg::WWD_CLOSED;
                    end
                end
                default: begin
                    next_state = wwd_pkg::WWD_SUPPLY_LOW;
                end
            endcase
        end
    end

    wire entering = (next_state != state);
    wire to_reset = entering & ((next_state == wwd_pkg::WWD_RESET) |
                                (next_state == wwd_pkg::WWD_SUPPLY_LOW) | (next_state == wwd_pkg::WWD_POR));

    // a load on every state change sets the length of the new interval
    assign tif.load = entering;
    assign tif.len  = (next_state == wwd_pkg::WWD_POR)    ? POR_LEN :
                      (next_state == wwd_pkg::WWD_CLOSED) ? CW_LEN  :
                      (next_state == wwd_pkg::WWD_OPEN)   ? OW_LEN  : WDR_LEN;

    assign next_svc_count = to_reset                ? wwd_pkg::SVC_COUNT_RST :
                            (good_svc && !svc_done) ? svc_count + 2'h1 : svc_count;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state     <= wwd_pkg::WWD_SUPPLY_LOW;
            svc_count <= wwd_pkg::SVC_COUNT_RST;
        end else begin
            state     <= next_state;
            svc_count <= next_svc_count;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign system_reset_n    = 1'b0;
    assign system_reset_oe_n = ~reset_act;
    assign system_enable_n   = reset_act | ~svc_done;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    enable_off_reset_a: assert property (@(posedge clk) disable iff (!resetn)
        !system_reset_oe_n |-> system_enable_n)
        else $error("enable active while reset active");

    supply_override_a: assert property (@(posedge clk) disable iff (!resetn)
        !sup_sync |=> !system_reset_oe_n && system_enable_n && svc_count == 2'h0)
        else $error("supply low did not force reset");

    por_holds_reset_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(state == wwd_pkg::WWD_POR) |-> !system_reset_oe_n [*8])
        else $error("reset released early in power-on delay");

    por_ignores_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        (state == wwd_pkg::WWD_POR) && clr_fall && sup_sync && !tif.expired
        |=> state == wwd_pkg::WWD_POR)
        else $error("clear acted during power-on delay");

    por_release_a: assert property (@(posedge clk) disable iff (!resetn)
        (state == wwd_pkg::WWD_POR) && tif.expired && sup_sync
        |=> system_reset_oe_n && in_closed)
        else $error("reset not released after power-on delay");

    service_restart_a: assert property (@(posedge clk) disable iff (!resetn)
        good_svc && sup_sync |=> in_closed && svc_count == ($past(svc_done) ? 2'h3 : $past(svc_count) + 2'h1))
        else $error("open-window service did not restart cycle");

    early_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        early_svc && sup_sync |=> !system_reset_oe_n && svc_count == 2'h0)
        else $error("early service gave no reset");

    timeout_reset_a: assert property (@(posedge clk) disable iff (!resetn)
        in_open && tif.expired && !clr_fall && sup_sync |=> (state == wwd_pkg::WWD_RESET))
        else $error("open window ended without reset");

    enable_needs_three_a: assert property (@(posedge clk) disable iff (!resetn)
        $fell(system_enable_n) |-> $past(good_svc) && svc_count == 2'h3)
        else $error("enable without three services");

    fail_loop_a: assert property (@(posedge clk) disable iff (!resetn)
        (state == wwd_pkg::WWD_RESET) && tif.expired && sup_sync |=> in_closed && system_reset_oe_n)
        else $error("reset pulse did not return to closed window");

    cover_good_service_c: cover property (@(posedge clk) disable iff (!resetn) good_svc);
    cover_early_service_c: cover property (@(posedge clk) disable iff (!resetn) early_svc);
    cover_enable_c: cover property (@(posedge clk) disable iff (!resetn) $fell(system_enable_n));
    cover_supply_dip_c: cover property (@(posedge clk) disable iff (!resetn) (in_closed || in_open) && !sup_sync);

endmodule // wwd_supervisor

// ### src/wwd_timer_if.sv
// Purpose: carrier between the watchdog sequencer and its interval timer
// Assumes: single clock domain
// Notes:   load restarts the interval and its tick prescaler

`timescale 1ns/1ns

interface wwd_timer_if;
    logic                       load;
    logic [wwd_pkg::TICK_W-1:0] len;
    logic                       expired;

    modport ctl (output load, output len, input expired);
    modport tmr (input load, input len, output expired);
endinterface

// ### test/test_windowed_watchdog_enable.sv
// Purpose: self-checking bench for the windowed watchdog supervisor
// Assumes: shortened tick counts, 10 MHz clock
// Notes:   window lengths are checked on the resolved reset pin

`timescale 1ns/1ns

module test_windowed_watchdog_enable;
    localparam int TC = 2;
    localparam int CWT = 8;
    localparam int OWT = 4;
    localparam int WDT = 2;
    localparam int PT = 10;

    logic       clk;
    logic       resetn;
    logic       supply_ok;
    logic       active;
    logic       chatter;
    logic [7:0] gap;
    wire logic  clear_n;
    wire logic  system_reset_n;
    wire logic  system_reset_oe_n;
    wire logic  system_enable_n;
    wire logic  reset_pin;
    int         bad_count;
    int         n_checks;
    int         cycles;
    int         pin_lows;
    logic       prev_pin;
    logic [31:0] rnd;

    // pull-up wins whenever the open-drain driver is off
    assign reset_pin = system_reset_oe_n ? 1'b1 : system_reset_n;

    wwd_supervisor #(.TICK_CYCLES(TC), .CW_TICKS(CWT), .OW_TICKS(OWT), .WDR_TICKS(WDT), .POR_TICKS(PT)) dut (
        .clk              (clk),
        .resetn           (resetn),
        .watchdog_clear_n (clear_n),
        .supply_ok        (supply_ok),
        .system_reset_n   (system_reset_n),
        .system_reset_oe_n(system_reset_oe_n),
        .system_enable_n  (system_enable_n)
    );

    wwd_host_model host (
        .clk      (clk),
        .resetn   (resetn),
        .reset_pin(reset_pin),
        .active   (active),
        .chatter  (chatter),
        .gap      (gap),
        .clear_n  (clear_n)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic int span(input int ticks);
        return ticks * TC + 1;
    endfunction

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_pin(input logic v, output int n);
        n = 0;
        while (reset_pin !== v && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // supply rises with the host chattering early in the delay
    task automatic power_up();
        int n;
        @(posedge clk);
        supply_ok <= 1'b1;
        #1;
        tick(11);
        @(posedge clk);
        chatter <= 1'b0;
        #1;
        wait_pin(1'b1, n);
        check("por length", span(PT) + 3 - 12, n);
        check("enable after por", 1'b1, system_enable_n);
    endtask

    // three good services from the start of a closed window
    task automatic run_services(input int g);
        int lows;
        @(posedge clk);
        gap    <= g[7:0];
        active <= 1'b1;
        lows = pin_lows;
        tick(3 * (g + 4) - g / 2);
        check("enable after two", 1'b1, system_enable_n);
        tick(g);
        check("enable after three", 1'b0, system_enable_n);
        check("no reset while serviced", lows, pin_lows);
        $display("test services gap %0d done", g);
    endtask

    // ------------------------------------------------------------
    // clock, monitor, timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(negedge clk) begin
        prev_pin <= reset_pin;
        if (prev_pin === 1'b1 && reset_pin === 1'b0) pin_lows++;
        if (resetn && reset_pin === 1'b0) check("enable during reset", 1'b1, system_enable_n);
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        resetn    = 1'b0;
        supply_ok = 1'b0;
        active    = 1'b0;
        chatter   = 1'b1;
        gap       = 8'h10;
        bad_count = 0;
        n_checks  = 0;
        cycles    = 0;
        pin_lows  = 0;
        prev_pin  = 1'b1;
        rnd       = 32'h35ec437f;
        tick(16);
        check("reset held", 1'b0, reset_pin);
        @(posedge clk);
        resetn <= 1'b1;
        tick(4);
        power_up();
        $display("test power up done");
        for (int i = 0; i < 3; i++) begin
            wait_pin(1'b0, n);
            check("closed plus open", span(CWT) + span(OWT), n);
            wait_pin(1'b1, n);
            check("timeout pulse", span(WDT), n);
        end
        $display("test missing service done");
        rnd = xorshift(rnd);
        run_services(16 + int'(rnd % 5));
        @(posedge clk);
        active <= 1'b0;
        #1;
        wait_pin(1'b0, n);
        wait_pin(1'b1, n);
        @(posedge clk);
        gap    <= 8'h05;
        active <= 1'b1;
        #1;
        wait_pin(1'b0, n);
        check("early reset in closed", 1'b1, n < span(CWT));
        wait_pin(1'b1, n);
        check("early pulse", span(WDT), n);
        rnd = xorshift(rnd);
        run_services(16 + int'(rnd % 5));
        $display("test early service done");
        @(posedge clk);
        supply_ok <= 1'b0;
        chatter   <= 1'b1;
        tick(3);
        check("supply low reset", 1'b0, reset_pin);
        check("supply low enable", 1'b1, system_enable_n);
        tick(10);
        power_up();
        rnd = xorshift(rnd);
        run_services(16 + int'(rnd % 5));
        $display("test supply dip done");
        report_and_stop();
    end
endmodule // test_windowed_watchdog_enable

// ### test/wwd_host_model.sv
// Purpose: host model that services the watchdog clear pin
// Assumes: reset_pin is the resolved open-drain reset level
// Notes:   the clear line idles high, driven high by the model itself

`timescale 1ns/1ns

module wwd_host_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       reset_pin,
    input  wire logic       active,
    input  wire logic       chatter,
    input  wire logic [7:0] gap,
    output logic            clear_n
);
    logic prev_pin;
    int   cnt;
    int   low_left;

    // ------------------------------------------------------------
    // service timing, counted from the start of each closed window
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clear_n  <= 1'b1;
            prev_pin <= 1'b0;
            cnt      <= 0;
            low_left <= 0;
        end else begin
            prev_pin <= reset_pin;
            clear_n  <= 1'b1;
            if (low_left != 0) begin
                low_left <= low_left - 1;
                clear_n  <= (low_left == 1);
            end
            if (chatter) begin
                clear_n <= ~clear_n;
            end
            // clear the window count to zero while reset is active, restart on release
            if (!reset_pin) begin
                cnt <= 0;
            end else if (!prev_pin) begin
                cnt <= 1;
            end else if (active && !chatter && cnt == int'(gap)) begin
                clear_n  <= 1'b0;
                low_left <= 2;
                cnt      <= -3;    // next window starts when the device takes the edge
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // wwd_host_model
